/* rtl/dbm_ctrl.sv */
/*
  DMA bus-master control: requests, grant blocking or passing, acknowledge,
  mastership, release, vector-accepted, drive initialise and missed-transfer
  watchdog, with an APB register slave.
  Assumes all bus inputs are synchronous to core_clk_i.
*/
// The register offsets and the APB register port were left to the implementer.
// What this block does
// - Slave sync on vector yields vector-accepted pulse clearing latch and busy.
// - Request only with transfer request, no end-request, ack and busy reset.
// - Transfer request stays active over one or two back-to-back cycles.
// - Request is driven only on the selected bus.
// - Grant on selected bus while requesting is blocked, not passed.
// - Acknowledge set a settling delay after the grant arrives.
// - Acknowledge set drives SACK and withdraws request.
// - Busy set with ack held, grant gone, BBSY and SSYN released.
// - Master drives BBSY, raises master flag, keeps request suppressed.
// - Acknowledge clears once busy is set and clear enable is active.
// - Grant on unselected bus is passed on and dropped with it.
// - End-of-request resets busy and releases the bus.
// - Primary bus init or power-low yields drive-bus initialise.
// - Program clear gives one fixed pulse that also initialises drives.
// - Read bus carries high byte of status one or two per select.
// - Busy start and each drive sync pulse restart missed-transfer timer.
// - Timer expiry while busy sets preflag then error, unless disabled.
// - Timer and preflag held clear by clear, not busy, or occupied.
// - Error flag clears only on the error-clear signal.
`timescale 1ns/1ps
module dbm_ctrl #(
  parameter int unsigned WATCHDOG_CYCLES = dbm_pkg::WATCHDOG_CYC
) (
  input wire logic core_clk_i, // Block clock, 25 MHz
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [11:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  input wire logic transfer_request_i, // Sequencer wants a transfer
  input wire logic end_transfer_request_i, // Sequencer ends mastership
  input wire logic vector_ssyn_i, // Slave sync on interrupt vector
  input wire logic [1:0] npg_i, // Non-processor grant in, per bus
  input wire logic [1:0] bbsy_i, // Bus busy seen, per bus
  input wire logic [1:0] ssyn_i, // Slave sync seen, per bus
  input wire logic pri_init_i, // Primary bus initialise
  input wire logic pri_power_low_i, // Primary bus power low
  input wire logic ctrl_busy_i, // Controller busy (not ready)
  input wire logic drive_sync_i, // Drive sync clock pulse
  input wire logic drive_bus_occupied_i, // Drive bus occupied line
  input wire logic controller_clear_i, // Controller clear
  input wire logic status_one_high_select_n_i, // Gate status-one high byte, low
  input wire logic status_two_high_select_n_i, // Gate status-two high byte, low
  input wire logic [7:0] status_one_high_i, // Status-one high byte
  output logic [1:0] npr_o, // Non-processor request out, per bus
  output logic [1:0] sack_o, // Selection acknowledge out, per bus
  output logic [1:0] bbsy_o, // Bus busy driven, per bus
  output logic [1:0] npg_out_o, // Grant passed down the chain
  output logic dma_master_flag_o, // Starts transfer sequencer
  output logic vector_accepted_o, // One-cycle vector-accepted pulse
  output logic drive_bus_init_o, // Drive-bus initialise
  output logic program_clear_pulse_o, // Fixed-length clear pulse
  output logic missed_transfer_error_o, // Missed-transfer error flag
  output logic [7:0] internal_read_bus_o // High-byte read bus
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] ctrl;
    logic [1:0] npr;
    logic [1:0] sack_out;
    logic [1:0] bbsy_out;
    logic [1:0] pass;
    logic ack;
    logic busy;
    logic master;
    logic vacc;
    logic vss_q;
    logic [3:0] settle;
    logic settling;
    logic [3:0] clr_cnt;
    logic pclr;
    logic [7:0] pulse_len;
    logic init;
    logic [dbm_pkg::CNT_W-1:0] wdog;
    logic busy_q;
    logic pre;
    logic missed_transfer_error;
    logic [7:0] rbus;
  } dbm_state_t;

  dbm_state_t st_r;
  dbm_state_t st_nxt;
  logic sel;
  logic wr_acc;
  logic rd_acc;
  logic sel_npg;
  logic sel_bbsy;
  logic sel_ssyn;
  logic req_ok;
  logic wd_hold;

  ////////////////////////////////////////////////////////////////////////////
  // Known register address
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == dbm_pkg::CTRL_OFS) || (a == dbm_pkg::STAT2_OFS) ||
              (a == dbm_pkg::STATE_OFS) || (a == dbm_pkg::READ_BUS_OFS);
  endfunction : addr_ok

  // Decodes shared by the next-state logic
  always_comb begin
    sel = st_r.ctrl[dbm_pkg::CTRL_PORT_SEL];
    wr_acc = psel_i && penable_i && pwrite_i && !st_r.pready;
    rd_acc = psel_i && !penable_i && !pwrite_i;
    sel_npg = npg_i[sel];
    sel_bbsy = bbsy_i[sel];
    sel_ssyn = ssyn_i[sel];
    req_ok = transfer_request_i && !end_transfer_request_i;
    wd_hold = controller_clear_i || !ctrl_busy_i || drive_bus_occupied_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    // APB: one wait state, ready in the access cycle's second edge
    st_nxt.pready = psel_i && penable_i && !st_r.pready;
    st_nxt.pslverr = psel_i && penable_i && !st_r.pready && !addr_ok(paddr_i);
    if (rd_acc) begin
      case (paddr_i)
        dbm_pkg::CTRL_OFS: st_nxt.prdata = {29'h0000_0000, st_r.ctrl};
        dbm_pkg::STAT2_OFS: st_nxt.prdata = {22'h00_0000, st_r.missed_transfer_error, 9'h000};
        dbm_pkg::STATE_OFS: st_nxt.prdata = {26'h000_0000, st_r.pre, st_r.init,
                                             st_r.master, st_r.busy, st_r.ack,
                                             st_r.settling};
        dbm_pkg::READ_BUS_OFS: st_nxt.prdata = {24'h00_0000, st_r.rbus};
        default: st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    if (wr_acc && paddr_i == dbm_pkg::CTRL_OFS) begin
      st_nxt.ctrl = pwdata_i[2:0];
    end

    // Grant passing on the unselected bus, cleared when grant drops
    for (int b = 0; b < 2; b++) begin
      st_nxt.pass[b] = npg_i[b] && (b != int'(sel));
    end
    // Selected-bus grant never passes down while we request
    // (pass bit for sel is forced low above)

    // Settling counter before acknowledge
    if (!st_r.settling && !st_r.ack && sel_npg && st_r.npr[sel]) begin
      st_nxt.settling = 1'b1;
      st_nxt.settle = 4'h0;
    end else if (st_r.settling) begin
      st_nxt.settle = st_r.settle + 4'h1;
      if (st_r.settle == 4'(dbm_pkg::GRANT_SETTLE_CYC - 1)) begin
        st_nxt.settling = 1'b0;
        st_nxt.ack = 1'b1;
      end
    end

    // Take mastership once grant gone and current master idle
    if (st_r.ack && !st_r.busy && !sel_npg && !sel_bbsy && !sel_ssyn) begin
      st_nxt.busy = 1'b1;
    end
    if (st_r.busy && st_r.ctrl[dbm_pkg::CTRL_ACK_CLR_EN]) begin
      st_nxt.ack = 1'b0;
    end
    // Release on end of request or vector accepted
    // Edge of slave sync, so a held level gives one pulse only
    st_nxt.vss_q = vector_ssyn_i;
    st_nxt.vacc = vector_ssyn_i && !st_r.vss_q;
    if (st_r.busy && (end_transfer_request_i || st_r.vacc)) begin
      st_nxt.busy = 1'b0;
    end
    if (controller_clear_i) begin
      st_nxt.busy = 1'b0;
      st_nxt.ack = 1'b0;
      st_nxt.settling = 1'b0;
    end
    st_nxt.master = st_nxt.busy;
    st_nxt.sack_out = 2'b00;
    st_nxt.sack_out[sel] = st_nxt.ack;
    st_nxt.bbsy_out = 2'b00;
    st_nxt.bbsy_out[sel] = st_nxt.busy;
    // Request from the next ack and busy, so it drops in the cycle that SACK
    // rises; the registered ack would leave it up one cycle too long
    st_nxt.npr = 2'b00;
    st_nxt.npr[sel] = req_ok && !st_nxt.ack && !st_nxt.busy;

    // Program clear one-shot, written via bit five of status two
    if (wr_acc && paddr_i == dbm_pkg::STAT2_OFS && pwdata_i[dbm_pkg::STAT2_CLEAR_BIT]) begin
      st_nxt.pclr = 1'b1;
      st_nxt.clr_cnt = 4'h0;
      st_nxt.pulse_len = 8'h00;
    end else if (st_r.pclr) begin
      st_nxt.clr_cnt = st_r.clr_cnt + 4'h1;
      // Width seen at the pin, counted apart from clr_cnt for the length check
      st_nxt.pulse_len = st_r.pulse_len + 8'h01;
      if (st_r.clr_cnt == 4'(dbm_pkg::CLEAR_PULSE_CYC - 1)) begin
        st_nxt.pclr = 1'b0;
      end
    end else begin
      st_nxt.pulse_len = 8'h00;
    end
    st_nxt.init = pri_init_i || pri_power_low_i || st_nxt.pclr;

    // Missed-transfer watchdog, restarted on busy entry and sync pulses
    st_nxt.busy_q = ctrl_busy_i;
    if (wd_hold) begin
      st_nxt.wdog = '0;
      st_nxt.pre = 1'b0;
    end else if ((ctrl_busy_i && !st_r.busy_q) || drive_sync_i) begin
      st_nxt.wdog = '0;
    end else if (st_r.wdog == dbm_pkg::CNT_W'(WATCHDOG_CYCLES - 1)) begin
      st_nxt.wdog = '0;
      if (!st_r.ctrl[dbm_pkg::CTRL_TMO_DIS]) begin
        st_nxt.pre = 1'b1;
      end
    end else begin
      st_nxt.wdog = st_r.wdog + 1'b1;
    end
    // Error flag: cleared only by error clear, a set in the same cycle wins
    if (wr_acc && paddr_i == dbm_pkg::STAT2_OFS && pwdata_i[dbm_pkg::STAT2_ERR_CLR_BIT]) begin
      st_nxt.missed_transfer_error = 1'b0;
    end
    if (st_r.pre || (wr_acc && paddr_i == dbm_pkg::STAT2_OFS &&
                     pwdata_i[dbm_pkg::STAT2_MXF_BIT])) begin
      st_nxt.missed_transfer_error = 1'b1;
    end

    // Read bus: high byte of status one or two
    if (!status_one_high_select_n_i) begin
      st_nxt.rbus = status_one_high_i;
    end else if (!status_two_high_select_n_i) begin
      st_nxt.rbus = {6'h00, st_nxt.missed_transfer_error, 1'b0};
    end else begin
      st_nxt.rbus = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
      st_r.ctrl <= dbm_pkg::CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata_o = st_r.prdata;
  assign pready_o = st_r.pready;
  assign pslverr_o = st_r.pslverr;
  assign npr_o = st_r.npr;
  assign sack_o = st_r.sack_out;
  assign bbsy_o = st_r.bbsy_out;
  assign npg_out_o = st_r.pass;
  assign dma_master_flag_o = st_r.master;
  assign vector_accepted_o = st_r.vacc;
  assign drive_bus_init_o = st_r.init;
  assign program_clear_pulse_o = st_r.pclr;
  assign missed_transfer_error_o = st_r.missed_transfer_error;
  assign internal_read_bus_o = st_r.rbus;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_grant_taken;
    npg_i[sel] && npr_o[sel] && !st_r.settling && !st_r.ack;
  endsequence

  property p_no_npr_when_busy;
    @(posedge core_clk_i) disable iff (!reset_n_i) (st_r.busy || st_r.ack) |-> npr_o == 2'b00;
  endproperty
  a_no_npr_when_busy: assert property (p_no_npr_when_busy) else $error("request while acked");

  property p_npr_sel;
    @(posedge core_clk_i) disable iff (!reset_n_i) npr_o[!sel] == 1'b0 || $changed(sel);
  endproperty
  a_npr_sel: assert property (p_npr_sel) else $error("request on other bus");

  property p_block;
    @(posedge core_clk_i) disable iff (!reset_n_i) npr_o[sel] && !$changed(sel) |-> !npg_out_o[sel];
  endproperty
  a_block: assert property (p_block) else $error("grant passed while requesting");

  property p_ack_delay;
    @(posedge core_clk_i) disable iff (!reset_n_i || controller_clear_i)
      // Start edge plus three settle edges before ack stands in the flop
      s_grant_taken |-> ##4 st_r.ack;
  endproperty
  a_ack_delay: assert property (p_ack_delay) else $error("ack not set after settle");

  property p_busy_cond;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $rose(st_r.busy) |-> $past(st_r.ack) && !$past(npg_i[sel]) &&
                           !$past(bbsy_i[sel]) && !$past(ssyn_i[sel]);
  endproperty
  a_busy_cond: assert property (p_busy_cond) else $error("busy set too early");

  property p_master;
    @(posedge core_clk_i) disable iff (!reset_n_i) dma_master_flag_o == st_r.busy && bbsy_o[sel] == st_r.busy;
  endproperty
  a_master: assert property (p_master) else $error("master flag mismatch");

  property p_release;
    @(posedge core_clk_i) disable iff (!reset_n_i) st_r.busy && end_transfer_request_i |=> !st_r.busy;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");

  property p_pclr_len;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      $fell(program_clear_pulse_o) |-> st_r.pulse_len == 8'(dbm_pkg::CLEAR_PULSE_CYC);
  endproperty
  a_pclr_len: assert property (p_pclr_len) else $error("clear pulse length");

  property p_init;
    @(posedge core_clk_i) disable iff (!reset_n_i) pri_init_i |=> drive_bus_init_o;
  endproperty
  a_init: assert property (p_init) else $error("no drive init");

  property p_hold;
    @(posedge core_clk_i) disable iff (!reset_n_i) wd_hold |=> st_r.wdog == '0 && !st_r.pre;
  endproperty
  a_hold: assert property (p_hold) else $error("watchdog not held");

  property p_mxf_sticky;
    @(posedge core_clk_i) disable iff (!reset_n_i) missed_transfer_error_o && !(wr_acc && paddr_i == dbm_pkg::STAT2_OFS) |=> missed_transfer_error_o;
  endproperty
  a_mxf_sticky: assert property (p_mxf_sticky) else $error("error flag lost");

  // One pulse per rising slave sync; a held level must not give a second
  sequence s_vacc_pulse;
    vector_accepted_o ##1 !vector_accepted_o;
  endsequence

  property p_vacc;
    @(posedge core_clk_i) disable iff (!reset_n_i) $rose(vector_ssyn_i) |=> s_vacc_pulse;
  endproperty
  a_vacc: assert property (p_vacc) else $error("vector accepted pulse");

  property p_vacc_release;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      st_r.busy && vector_accepted_o |=> !st_r.busy;
  endproperty
  a_vacc_release: assert property (p_vacc_release) else $error("bus kept after vector");

  property p_ack_clear;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      st_r.busy && st_r.ctrl[dbm_pkg::CTRL_ACK_CLR_EN] |=> !st_r.ack;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("ack not cleared");

  // Request must be gone by the cycle in which the acknowledge appears
  property p_sack_npr;
    @(posedge core_clk_i) disable iff (!reset_n_i) $rose(|sack_o) |-> npr_o == 2'b00;
  endproperty
  a_sack_npr: assert property (p_sack_npr) else $error("request kept with ack");

  // With the secondary port selected, the primary grant is passed a cycle late
  property p_pass;
    @(posedge core_clk_i) disable iff (!reset_n_i) sel |=> npg_out_o[0] == $past(npg_i[0]);
  endproperty
  a_pass: assert property (p_pass) else $error("grant not passed");

  property p_init_low;
    @(posedge core_clk_i) disable iff (!reset_n_i) pri_power_low_i |=> drive_bus_init_o;
  endproperty
  a_init_low: assert property (p_init_low) else $error("no drive init on power low");

  property p_rbus;
    @(posedge core_clk_i) disable iff (!reset_n_i)
      !status_one_high_select_n_i |=> internal_read_bus_o == $past(status_one_high_i);
  endproperty
  a_rbus: assert property (p_rbus) else $error("read bus not status one");
endmodule : dbm_ctrl

/* pkg/dbm_pkg.sv */
/*
  Constants for the DMA bus-master control block: APB register map, field
  positions, reset values and timing counts.
  Assumes a 25 MHz block clock and a 32-bit APB master.
*/
package dbm_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CLK_NS = 40;
  // Timing figures in their own units
  localparam int unsigned GRANT_SETTLE_NS = 100;
  localparam int unsigned CLEAR_PULSE_NS = 400;
  localparam int unsigned WATCHDOG_MS = 250;
  // Derived counts: least times round up, longest round down
  localparam int unsigned GRANT_SETTLE_CYC = (GRANT_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CLEAR_PULSE_CYC = (CLEAR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WATCHDOG_CYC = (CLK_HZ / 1000) * WATCHDOG_MS;
  localparam int unsigned CNT_W = 23;
  // Register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT2_OFS = 12'h004;
  localparam logic [11:0] STATE_OFS = 12'h008;
  localparam logic [11:0] READ_BUS_OFS = 12'h00C;
  // Control register fields
  localparam int CTRL_PORT_SEL = 0;
  localparam int CTRL_ACK_CLR_EN = 1;
  localparam int CTRL_TMO_DIS = 2;
  // Second control/status fields
  localparam int STAT2_CLEAR_BIT = 5;
  localparam int STAT2_MXF_BIT = 9;
  localparam int STAT2_ERR_CLR_BIT = 14;
  localparam logic [2:0] CTRL_RST = 3'h2;
endpackage : dbm_pkg

/* tb/dbm_arb_model.sv */
/*
  Model of the processor arbiter and of the current bus master, one per bus.
  Assumes the block's requests and acknowledges are registered on clk.
*/
`timescale 1ns/1ps
module dbm_arb_model (
  input wire logic clk, // Block clock
  input wire logic rst_n, // Reset, active low
  input wire logic [1:0] npr, // Requests from the block
  input wire logic [1:0] sack, // Acknowledges from the block
  input wire logic [1:0] bbsy_dev, // Bus busy driven by the block
  input wire logic [1:0] pass_req, // Another device asks on this bus
  input wire logic [3:0] dly, // Grant delay and master hold, cycles
  output logic [1:0] npg, // Grants to the block
  output logic [1:0] bbsy, // Busy of the current master
  output logic [1:0] ssyn // Slave sync of the current master
);
  int wt [2];
  int hold [2];
  ////////////////////////////////////////////////////////////////////////
  // Grant after a delay; the old master keeps the bus a while, so a slow
  // answer tests that the block waits for both lines to drop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      npg <= 2'h0;
      bbsy <= 2'h0;
      ssyn <= 2'h0;
      wt <= '{0, 0};
      hold <= '{0, 0};
    end else begin
      for (int b = 0; b < 2; b++) begin
        bbsy[b] <= hold[b] != 0;
        ssyn[b] <= hold[b] > 1;
        if (hold[b] != 0 && !npg[b]) hold[b] <= hold[b] - 1;
        if (npg[b]) begin
          if (sack[b] || !(npr[b] || pass_req[b])) npg[b] <= 1'b0;
        end else if ((npr[b] || pass_req[b]) && !sack[b] && !bbsy_dev[b]) begin
          if (wt[b] >= int'(dly)) begin
            npg[b] <= 1'b1;
            hold[b] <= int'(dly);
            wt[b] <= 0;
          end else begin
            wt[b] <= wt[b] + 1;
          end
        end
      end
    end
  end
endmodule : dbm_arb_model

/* tb/dbm_ctrl_tb.sv */
/*
  Self-checking bench for dbm_ctrl: APB master, arbitration on both buses,
  vector accept, drive initialise and the missed-transfer watchdog.
  Assumes the watchdog is shortened to 50 cycles.
*/
`timescale 1ns/1ps
module dbm_ctrl_tb;
  localparam int WD = 50;
  logic clk, rst_n, psel, pen, pwr, rdy, err, tr, etr, vss, pinit, plow, busy, dsync, drive_bus_occupied, clr;
  logic s1n, s2n, mflag, vacc, dinit, pclr, missed_transfer_error;
  logic [11:0] pa;
  logic [31:0] pwd, prd, q;
  logic [7:0] s1h, rbus;
  logic [1:0] npg, bbsy, ssyn, npr, sack, bbo, npgo, preq;
  logic [3:0] dly;
  int failures, n_tests, i, seed;
  logic prev;
  ////////////////////////////////////////////////////////////////////////
  dbm_ctrl #(.WATCHDOG_CYCLES(WD)) dut (.core_clk_i(clk), .reset_n_i(rst_n), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(rdy), .pslverr_o(err), .transfer_request_i(tr), .end_transfer_request_i(etr),
    .vector_ssyn_i(vss), .npg_i(npg), .bbsy_i(bbsy), .ssyn_i(ssyn), .pri_init_i(pinit),
    .pri_power_low_i(plow), .ctrl_busy_i(busy), .drive_sync_i(dsync),
    .drive_bus_occupied_i(drive_bus_occupied), .controller_clear_i(clr), .status_one_high_select_n_i(s1n),
    .status_two_high_select_n_i(s2n), .status_one_high_i(s1h), .npr_o(npr), .sack_o(sack),
    .bbsy_o(bbo), .npg_out_o(npgo), .dma_master_flag_o(mflag), .vector_accepted_o(vacc),
    .drive_bus_init_o(dinit), .program_clear_pulse_o(pclr),
    .missed_transfer_error_o(missed_transfer_error), .internal_read_bus_o(rbus));
  dbm_arb_model arb (.clk(clk), .rst_n(rst_n), .npr(npr), .sack(sack), .bbsy_dev(bbo),
    .pass_req(preq), .dly(dly), .npg(npg), .bbsy(bbsy), .ssyn(ssyn));
  // Clock at 25 MHz
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  // Bounded wait; running out ends the run
  task tmo(input int k);
    if (k >= 200) begin
      failures++;
      results();
    end
  endtask : tmo
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (rdy) break;
    end
    tmo(i);
    q = prd;
    psel <= 0; pen <= 0;
  endtask : apb
  ////////////////////////////////////////////////////////////////////////
  // One arbitration and mastership on bus b
  task own(input int b, input logic vec);
    tr <= 1;
    for (i = 0; i < 200 && !npr[b]; i++) @(posedge clk);
    tmo(i);
    chk("npr_other", 0, npr[1-b]);
    for (i = 0; i < 200 && !npg[b]; i++) @(posedge clk);
    tmo(i);
    repeat (2) @(posedge clk);
    chk("npg_blocked", 0, npgo[b]);
    for (i = 0; i < 200 && !sack[b]; i++) @(posedge clk);
    tmo(i);
    chk("npr_withdrawn", 0, npr[b]);
    for (i = 0; i < 200 && !bbo[b]; i++) begin
      prev = npg[b] | bbsy[b] | ssyn[b];
      @(posedge clk);
    end
    tmo(i);
    chk("busy_wait", 0, prev);
    chk("master", 1, mflag);
    repeat (2) @(posedge clk);
    chk("sack_clear", 0, sack[b]);
    chk("npr_held", 0, npr);
    if (vec) vss <= 1;
    else etr <= 1;
    tr <= 0;
    for (i = 0; i < 200 && bbo[b]; i++) begin
      prev = vacc;
      @(posedge clk);
    end
    tmo(i);
    chk("released", vec, prev);
    chk("master_off", 0, mflag);
    vss <= 0; etr <= 0;
  endtask : own
  ////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0; n_tests = 0; seed = 32'h7378_0f4a;
    {psel, pen, pwr, tr, etr, vss, pinit, plow, busy, dsync, drive_bus_occupied, clr} = 0;
    {s1n, s2n} = 2'b11; pa = 0; pwd = 0; s1h = 0; preq = 0; dly = 0; rst_n = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1;
    apb(0, 12'h000, 0);
    chk("ctrl_reset", 32'h0000_0002, q);
    apb(0, 12'h010, 0);
    chk("unmapped", 1, err);
    own(0, 0);
    dly <= 4'h4;
    own(0, 0);
    apb(1, 12'h000, 32'h0000_0003);
    preq <= 2'b01;
    for (i = 0; i < 200 && !npg[0]; i++) @(posedge clk);
    tmo(i);
    @(posedge clk);
    chk("pass_on", 1, npgo[0]);
    preq <= 0;
    repeat (4) @(posedge clk);
    chk("pass_off", 0, npgo[0]);
    dly <= 4'($random(seed)) & 4'h7;
    own(1, 1);
    apb(1, 12'h004, 32'h0000_0020);
    for (i = 0; i < 200 && !pclr; i++) @(posedge clk);
    tmo(i);
    for (i = 0; i < 200 && pclr; i++) begin
      chk("init_clear", 1, dinit);
      @(posedge clk);
    end
    chk("clear_len", 10, i);
    pinit <= 1;
    repeat (3) @(posedge clk);
    chk("init_bus", 1, dinit);
    pinit <= 0; plow <= 1;
    repeat (3) @(posedge clk);
    chk("init_low", 1, dinit);
    plow <= 0;
    busy <= 1;
    repeat (4) begin
      repeat (30) @(posedge clk);
      dsync <= 1;
      @(posedge clk);
      dsync <= 0;
    end
    chk("wd_sync", 0, missed_transfer_error);
    repeat (WD + 10) @(posedge clk);
    chk("wd_expire", 1, missed_transfer_error);
    busy <= 0;
    repeat (10) @(posedge clk);
    chk("err_held", 1, missed_transfer_error);
    apb(1, 12'h004, 32'h0000_4000);
    apb(0, 12'h004, 0);
    chk("err_clear", 0, q[9]);
    apb(1, 12'h004, 32'h0000_0200);
    apb(0, 12'h004, 0);
    chk("err_force", 1, q[9]);
    apb(1, 12'h004, 32'h0000_4000);
    apb(1, 12'h000, 32'h0000_0006);
    busy <= 1;
    repeat (WD + 10) @(posedge clk);
    chk("wd_disabled", 0, missed_transfer_error);
    apb(1, 12'h000, 32'h0000_0002);
    drive_bus_occupied <= 1;
    repeat (WD + 10) @(posedge clk);
    chk("wd_occupied", 0, missed_transfer_error);
    busy <= 0; drive_bus_occupied <= 0;
    repeat (4) begin
      s1h <= 8'($random(seed));
      s1n <= 0;
      repeat (3) @(posedge clk);
      chk("read_bus", s1h, rbus);
    end
    s1n <= 1;
    s2n <= 0;
    apb(1, 12'h004, 32'h0000_0200);
    repeat (3) @(posedge clk);
    chk("read_bus_two", 32'h0000_0002, rbus);
    results();
  end
endmodule : dbm_ctrl_tb
